// *** common/caf_defs.svh ***
// constants for the can acceptance filter and status block
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`ifndef CAF_DEFS_SVH
`define CAF_DEFS_SVH
`define CAF_OFF_TEST 12'h000
`define CAF_OFF_MISC 12'h004
`define CAF_OFF_RXERR 12'h008
`define CAF_OFF_TXERR 12'h00C
`define CAF_OFF_IDAC 12'h010
`define CAF_OFF_MODE 12'h014
`define CAF_OFF_IRQ_STAT 12'h018
`define CAF_OFF_IRQ_MASK 12'h01C
`define CAF_OFF_CODE0 12'h020
`define CAF_OFF_MASK0 12'h040
`define CAF_BIT_BUSOFF_HOLD_FLAG 0
`define CAF_BIT_BUSOFF_RECOVERY_MODE 0
`define CAF_BIT_INIT_REQUEST 1
`define CAF_BIT_SLEEP_REQUEST 2
`define CAF_IRQ_ACCEPT 0
`define CAF_IRQ_BUSOFF 1
`define CAF_IRQ_DROP 2
`define CAF_RST_BYTE 8'h00
`define CAF_ACK_DELAY 4'h3
`endif

// *** common/caf_pkg.sv ***
// types for the can acceptance filter and status block
package caf_pkg;
    typedef enum logic [1:0]
    {
        CAF_MODE_32 = 2'b00,
        CAF_MODE_16 = 2'b01,
        CAF_MODE_8 = 2'b10,
        CAF_MODE_CLOSED = 2'b11
    } caf_mode_t;

    typedef enum logic [1:0]
    {
        CAF_BO_ACTIVE = 2'b00,
        CAF_BO_OFF = 2'b01,
        CAF_BO_RECOVER = 2'b11
    } caf_bo_t;

    typedef struct packed
    {
        logic valid;
        logic extended;
        logic [31:0] id_bytes;
    } caf_frame_t;

    typedef struct packed
    {
        logic busoff_enter;
        logic busoff_leave;
        logic [7:0] rx_errors;
        logic [7:0] tx_errors;
    } caf_engine_t;
endpackage : caf_pkg

// *** design/caf_match.sv ***
// filter match over all eight code/mask bytes, lowest hit reported
`timescale 1ns/100ps
module caf_match
(
    // filter setup
    input wire logic [63:0] codes,
    input wire logic [63:0] masks,
    input wire caf_pkg::caf_mode_t mode,
    // frame under test
    input wire logic [31:0] id_bytes,
    input wire logic extended,
    // result
    output logic hit,
    output logic [2:0] hit_num
);
    import caf_pkg::*;
    logic [7:0] byte_ok;
    logic [7:0] f_ok;
    logic [7:0] half_ok;

    // per byte, per id byte position
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_byte
            logic [7:0] idb;
            logic [7:0] idh;
            // code byte n meets id byte n mod 4, id byte 0 in high bits
            assign idb = id_bytes[31 - 8 * (g % 4) -: 8];
            // mask one ignores, mask zero must match
            assign byte_ok[g] = &((~(codes[8*g +: 8] ^ idb))
                | masks[8*g +: 8]);
            // 16-bit filters always meet id bytes 0 and 1
            assign idh = id_bytes[31 - 8 * (g % 2) -: 8];
            assign half_ok[g] = &((~(codes[8*g +: 8] ^ idh))
                | masks[8*g +: 8]);
        end
    endgenerate

    always_comb
    begin
        f_ok = 8'h00;
        hit = 1'b0;
        hit_num = 3'h0;
        case (mode)
            CAF_MODE_32:
            begin
                // standard ids only see the first two bytes of a bank
                f_ok[0] = extended ? &byte_ok[3:0] : &byte_ok[1:0];
                f_ok[1] = extended ? &byte_ok[7:4] : &byte_ok[5:4];
            end
            CAF_MODE_16:
            begin
                f_ok[0] = &half_ok[1:0];
                f_ok[1] = &half_ok[3:2];
                f_ok[2] = &half_ok[5:4];
                f_ok[3] = &half_ok[7:6];
            end
            CAF_MODE_8:
                f_ok = byte_ok;
            default:
                f_ok = 8'h00;
        endcase
        // scan downward so the lowest match wins
        for (int i = 7; i >= 0; i--)
        begin
            if (f_ok[i])
            begin
                hit = 1'b1;
                hit_num = 3'(i);
            end
        end
    end
endmodule : caf_match

// *** design/caf_top.sv ***
// can acceptance filter, bus-off hold and error counter windows
`timescale 1ns/100ps
`include "caf_defs.svh"
module caf_top
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // protocol engine side
    input wire caf_pkg::caf_frame_t rx_frame,
    input wire caf_pkg::caf_engine_t engine,
    input wire logic special_mode,
    output logic recovery_request,
    output logic busoff_held,
    // receive handoff
    output logic frame_accepted,
    output logic [31:0] fg_id_bytes,
    output logic [2:0] filter_hit_indicator,
    // interrupt
    output logic irq
);
    import caf_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [63:0] codes, next_codes;
    logic [63:0] masks, next_masks;
    caf_mode_t mode, next_mode;
    // hit indicator only moves together with the foreground buffer
    logic [2:0] hit_ind, next_hit_ind;
    logic [7:0] test_reg, next_test_reg;
    logic busoff_recovery_mode, next_busoff_recovery_mode;
    logic init_request, next_init_request;
    logic sleep_request, next_sleep_request;
    logic init_acknowledge, next_init_acknowledge;
    logic sleep_acknowledge, next_sleep_acknowledge;
    logic [3:0] ack_cnt, next_ack_cnt;
    caf_bo_t bo_state, next_bo_state;
    logic busoff_hold_flag, next_busoff_hold_flag;
    logic [2:0] irq_stat, next_irq_stat;
    logic [2:0] irq_mask, next_irq_mask;
    logic [31:0] bg_id, next_bg_id;
    logic bg_ext, next_bg_ext;
    logic bg_full, next_bg_full;
    logic [31:0] fg_id, next_fg_id;
    logic acc_pulse, next_acc_pulse;
    logic [31:0] rdata, next_rdata;
    // special mode strap passes three flops, change counted on agreement
    logic [2:0] spec_sync;
    logic spec_q, next_spec_q;

    logic wr_en, rd_en, init_mode, sleep_mode;
    logic m_hit;
    logic [2:0] m_num;

    assign wr_en = psel & penable & pwrite;
    // read data latched in setup so it stands through the access phase
    assign rd_en = psel & ~penable & ~pwrite;
    assign init_mode = init_request & init_acknowledge;
    assign sleep_mode = sleep_request & sleep_acknowledge;
    // zero wait states: every access phase lasts one cycle
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    caf_match u_match
    (
        .codes(codes),
        .masks(masks),
        .mode(mode),
        .id_bytes(bg_id),
        .extended(bg_ext),
        .hit(m_hit),
        .hit_num(m_num)
    );

    // ---------------------------------------------------------------
    // mode handshake: acknowledge follows request after a short delay
    // ---------------------------------------------------------------
    always_comb
    begin
        next_ack_cnt = ack_cnt;
        next_init_acknowledge = init_acknowledge;
        next_sleep_acknowledge = sleep_acknowledge;
        // sleep and init share one timer; both acks move together
        if ((init_request != init_acknowledge)
            || (sleep_request != sleep_acknowledge))
        begin
            if (ack_cnt == `CAF_ACK_DELAY)
            begin
                next_ack_cnt = 4'h0;
                next_init_acknowledge = init_request;
                next_sleep_acknowledge = sleep_request;
            end
            else
                next_ack_cnt = ack_cnt + 4'h1;
        end
        else
            next_ack_cnt = 4'h0;
    end

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always_comb
    begin
        next_codes = codes;
        next_masks = masks;
        next_mode = mode;
        next_test_reg = test_reg;
        next_busoff_recovery_mode = busoff_recovery_mode;
        next_init_request = init_request;
        next_sleep_request = sleep_request;
        next_irq_mask = irq_mask;
        next_spec_q = (spec_sync[1] == spec_sync[2]) ? spec_sync[2] : spec_q;
        if (wr_en)
        begin
            case (paddr)
                `CAF_OFF_TEST:
                    // only the synchronised strap opens the test register
                    if (spec_q)
                        next_test_reg = pwdata[7:0];
                `CAF_OFF_MODE:
                begin
                    // no guard: software may leave init mode at any time
                    next_busoff_recovery_mode = pwdata[`CAF_BIT_BUSOFF_RECOVERY_MODE];
                    next_init_request = pwdata[`CAF_BIT_INIT_REQUEST];
                    next_sleep_request = pwdata[`CAF_BIT_SLEEP_REQUEST];
                end
                `CAF_OFF_IDAC:
                    if (init_mode)
                        next_mode = caf_mode_t'(pwdata[5:4]);
                `CAF_OFF_IRQ_MASK:
                    next_irq_mask = pwdata[2:0];
                default:
                    if (init_mode && paddr[11:6] == 6'h00
                        && paddr[1:0] == 2'b00 && paddr[5])
                    begin
                        // codes at 0x20..0x3C, masks at 0x40..0x5C
                        next_codes[8*paddr[4:2] +: 8] = pwdata[7:0];
                    end
                    else if (init_mode && paddr[11:5] == 7'h02
                        && paddr[1:0] == 2'b00)
                    begin
                        next_masks[8*paddr[4:2] +: 8] = pwdata[7:0];
                    end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // bus-off hold and interrupt status
    // ---------------------------------------------------------------
    always_comb
    begin
        next_bo_state = bo_state;
        next_busoff_hold_flag = busoff_hold_flag;
        next_irq_stat = irq_stat;
        recovery_request = 1'b0;
        case (bo_state)
            CAF_BO_ACTIVE:
                if (engine.busoff_enter)
                begin
                    next_bo_state = CAF_BO_OFF;
                    // recovery mode clear: flag stays zero, leave is automatic
                    next_busoff_hold_flag = busoff_recovery_mode;
                end
            CAF_BO_OFF:
                if (busoff_hold_flag && wr_en && paddr == `CAF_OFF_MISC
                    && pwdata[`CAF_BIT_BUSOFF_HOLD_FLAG])
                begin
                    next_busoff_hold_flag = 1'b0;
                    next_bo_state = CAF_BO_RECOVER;
                end
                // leave is ignored while the flag still holds bus-off
                else if (engine.busoff_leave && !busoff_hold_flag)
                    next_bo_state = CAF_BO_ACTIVE;
            CAF_BO_RECOVER:
            begin
                // held high until engine leaves bus-off
                recovery_request = 1'b1;
                if (engine.busoff_leave)
                    next_bo_state = CAF_BO_ACTIVE;
            end
            default:
                next_bo_state = CAF_BO_ACTIVE;
        endcase
        // write one clears, a same-cycle event wins
        if (wr_en && paddr == `CAF_OFF_IRQ_STAT)
            next_irq_stat = irq_stat & ~pwdata[2:0];
        if (next_acc_pulse)
            next_irq_stat[`CAF_IRQ_ACCEPT] = 1'b1;
        if (bg_full && !m_hit)
            next_irq_stat[`CAF_IRQ_DROP] = 1'b1;
        if (engine.busoff_enter && bo_state == CAF_BO_ACTIVE)
            next_irq_stat[`CAF_IRQ_BUSOFF] = 1'b1;
    end

    // ---------------------------------------------------------------
    // receive path: background buffer, filter, foreground handoff
    // ---------------------------------------------------------------
    always_comb
    begin
        next_bg_id = bg_id;
        next_bg_ext = bg_ext;
        next_bg_full = 1'b0;
        next_fg_id = fg_id;
        next_hit_ind = hit_ind;
        next_acc_pulse = 1'b0;
        // every frame lands in background; a later one overwrites
        // frames one cycle apart are each filtered before the next overwrites
        if (rx_frame.valid)
        begin
            next_bg_id = rx_frame.id_bytes;
            next_bg_ext = rx_frame.extended;
            next_bg_full = 1'b1;
        end
        // closed mode never hits, so foreground never reloads
        if (bg_full && m_hit)
        begin
            next_fg_id = bg_id;
            next_hit_ind = m_num;
            next_acc_pulse = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (rd_en)
        begin
            case (paddr)
                `CAF_OFF_TEST:
                    next_rdata[7:0] = spec_q ? test_reg : 8'h00;
                `CAF_OFF_MISC:
                    next_rdata[`CAF_BIT_BUSOFF_HOLD_FLAG] = busoff_hold_flag;
                `CAF_OFF_RXERR:
                    if (init_mode || sleep_mode)
                        next_rdata[7:0] = engine.rx_errors;
                `CAF_OFF_TXERR:
                    if (init_mode || sleep_mode)
                        next_rdata[7:0] = engine.tx_errors;
                `CAF_OFF_IDAC:
                    next_rdata[7:0] = {2'b00, mode, 1'b0, hit_ind};
                `CAF_OFF_MODE:
                    next_rdata[7:0] = {3'b000, init_acknowledge,
                        sleep_acknowledge, sleep_request, init_request,
                        busoff_recovery_mode};
                `CAF_OFF_IRQ_STAT:
                    next_rdata[2:0] = irq_stat;
                `CAF_OFF_IRQ_MASK:
                    next_rdata[2:0] = irq_mask;
                default:
                    if (paddr[11:6] == 6'h00 && paddr[5]
                        && paddr[1:0] == 2'b00)
                        next_rdata[7:0] = codes[8*paddr[4:2] +: 8];
                    else if (paddr[11:5] == 7'h02 && paddr[1:0] == 2'b00)
                        next_rdata[7:0] = masks[8*paddr[4:2] +: 8];
            endcase
        end
        else if (psel && penable)
            next_rdata = rdata;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    // reset starts in init mode so the filter can be set up first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            codes <= 64'h0000_0000_0000_0000;
            masks <= 64'h0000_0000_0000_0000;
            mode <= CAF_MODE_32;
            hit_ind <= 3'h0;
            test_reg <= `CAF_RST_BYTE;
            busoff_recovery_mode <= 1'b0;
            init_request <= 1'b1;
            sleep_request <= 1'b0;
            init_acknowledge <= 1'b1;
            sleep_acknowledge <= 1'b0;
            ack_cnt <= 4'h0;
            bo_state <= CAF_BO_ACTIVE;
            busoff_hold_flag <= 1'b0;
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            bg_id <= 32'h0000_0000;
            bg_ext <= 1'b0;
            bg_full <= 1'b0;
            fg_id <= 32'h0000_0000;
            acc_pulse <= 1'b0;
            rdata <= 32'h0000_0000;
            spec_sync <= 3'h0;
            spec_q <= 1'b0;
        end
        else
        begin
            codes <= next_codes;
            masks <= next_masks;
            mode <= next_mode;
            hit_ind <= next_hit_ind;
            test_reg <= next_test_reg;
            busoff_recovery_mode <= next_busoff_recovery_mode;
            init_request <= next_init_request;
            sleep_request <= next_sleep_request;
            init_acknowledge <= next_init_acknowledge;
            sleep_acknowledge <= next_sleep_acknowledge;
            ack_cnt <= next_ack_cnt;
            bo_state <= next_bo_state;
            busoff_hold_flag <= next_busoff_hold_flag;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            bg_id <= next_bg_id;
            bg_ext <= next_bg_ext;
            bg_full <= next_bg_full;
            fg_id <= next_fg_id;
            acc_pulse <= next_acc_pulse;
            rdata <= next_rdata;
            spec_sync <= {spec_sync[1:0], special_mode};
            spec_q <= next_spec_q;
        end
    end

    assign prdata = rdata;
    assign frame_accepted = acc_pulse;
    assign fg_id_bytes = fg_id;
    assign filter_hit_indicator = hit_ind;
    assign busoff_held = busoff_hold_flag;
    assign irq = |(irq_stat & irq_mask);
endmodule : caf_top

// *** verif/caf_checker.sv ***
// assertion checker on the caf_top ports
`timescale 1ns/100ps
`include "caf_defs.svh"
module caf_checker
(
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // engine side
    input wire caf_pkg::caf_frame_t rx_frame,
    input wire caf_pkg::caf_engine_t engine,
    input wire logic special_mode,
    input wire logic recovery_request,
    input wire logic busoff_held,
    // receive handoff
    input wire logic frame_accepted,
    input wire logic [31:0] fg_id_bytes,
    input wire logic [2:0] filter_hit_indicator
);
    import caf_pkg::*;
    logic hold_w1;
    assign hold_w1 = psel && penable && pwrite
        && paddr == `CAF_OFF_MISC && pwdata[0];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // --------------------------------
    // sequences
    // --------------------------------
    // synchroniser needs the pin low for a while
    sequence s_test_setup;
        !special_mode [*5] ##0
        (psel && !penable && !pwrite && paddr == `CAF_OFF_TEST);
    endsequence
    sequence s_hold_clear;
        busoff_held && hold_w1;
    endsequence
    // --------------------------------
    // properties
    // --------------------------------
    a_test_zero: assert property (
        s_test_setup |=> prdata == 32'h0)
        else $error("test register read not zero");
    a_busoff_rose: assert property (
        $rose(busoff_held) |->
        $past(engine.busoff_enter) || $past(engine.busoff_enter, 2))
        else $error("hold flag rose without bus-off");
    a_hold_stays: assert property (
        busoff_held && !hold_w1 |=> busoff_held)
        else $error("hold flag dropped without request");
    a_hold_clear: assert property (
        s_hold_clear |=> !busoff_held && recovery_request)
        else $error("write one did not clear hold");
    a_req_leave: assert property (
        recovery_request |=>
        recovery_request != $past(engine.busoff_leave))
        else $error("recovery request wrong around leave");
    a_accept_one: assert property (
        frame_accepted |=> !frame_accepted)
        else $error("accept pulse too long");
    a_frame_late: assert property (
        frame_accepted |-> $past(rx_frame.valid, 2))
        else $error("accept without frame");
    a_fg_source: assert property (
        frame_accepted |-> fg_id_bytes == $past(rx_frame.id_bytes, 2))
        else $error("foreground id not the frame");
    a_fg_steady: assert property (
        !frame_accepted |->
        $stable(fg_id_bytes) && $stable(filter_hit_indicator))
        else $error("foreground changed without accept");
endmodule : caf_checker

bind caf_top caf_checker i_chk
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .rx_frame, .engine, .special_mode, .recovery_request,
    .busoff_held, .frame_accepted, .fg_id_bytes, .filter_hit_indicator
);

// *** verif/caf_bus_model.sv ***
// behavioural protocol engine feeding frames and bus-off events
`timescale 1ns/100ps
module caf_bus_model
(
    // clock
    input wire logic pclk,
    // toward the filter
    output caf_pkg::caf_frame_t rx_frame,
    output caf_pkg::caf_engine_t engine
);
    import caf_pkg::*;
    initial
    begin
        rx_frame = '0;
        engine = '0;
    end
    // id lines inverted after the pulse so nothing stale lingers
    task automatic send(input logic ext, input logic [31:0] id);
        @(posedge pclk);
        rx_frame <= '{1'b1, ext, id};
        @(posedge pclk);
        rx_frame <= '{1'b0, ext, ~id};
    endtask : send
    task automatic pulse(input logic enter);
        @(posedge pclk);
        engine.busoff_enter <= enter;
        engine.busoff_leave <= !enter;
        @(posedge pclk);
        engine.busoff_enter <= 1'b0;
        engine.busoff_leave <= 1'b0;
    endtask : pulse
    task automatic counts(input logic [7:0] rx, input logic [7:0] tx);
        @(posedge pclk);
        engine.rx_errors <= rx;
        engine.tx_errors <= tx;
    endtask : counts
endmodule : caf_bus_model

// *** verif/tb_can_acceptance_filter_status.sv ***
// self-checking bench for the acceptance filter block
`timescale 1ns/100ps
`include "caf_defs.svh"
`define CHK(nm, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            n_mismatch++; \
            $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
        end \
    end
module tb_can_acceptance_filter_status;
    import caf_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic special_mode = 1'b0;
    logic [31:0] prdata, fg_id_bytes;
    logic pready, pslverr, recovery_request, busoff_held, frame_accepted, irq;
    logic [2:0] filter_hit_indicator;
    caf_frame_t rx_frame;
    caf_engine_t engine;
    logic [31:0] seed = 32'hBED0;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [32:0] rd_q[$];
    logic [34:0] fr_q[$];
    always #10 pclk = ~pclk;
    caf_top i_dut
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rx_frame, .engine, .special_mode,
        .recovery_request, .busoff_held, .frame_accepted, .fg_id_bytes,
        .filter_hit_indicator, .irq
    );
    caf_bus_model i_bus (.pclk, .rx_frame, .engine);
    // --------------------------------
    // helpers
    // --------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 9);
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            stop_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rd_q.push_back({1'b0, e});
        apb(1'b0, a, 32'h0);
    endtask : rd
    // polls both acknowledges; these reads are not compared
    task automatic set_mode(input logic [31:0] v);
        int k;
        wr(`CAF_OFF_MODE, v);
        k = 0;
        do
        begin
            rd_q.push_back({1'b1, 32'h0});
            apb(1'b0, `CAF_OFF_MODE, 32'h0);
            k++;
        end
        while ((prdata[4] !== v[1] || prdata[3] !== v[2]) && k < 20);
        if (prdata[4] !== v[1] || prdata[3] !== v[2])
        begin
            n_mismatch++;
            stop_test();
        end
    endtask : set_mode
    task automatic load(input logic [63:0] cd, input logic [63:0] mk,
                        input logic [31:0] ctl);
        set_mode(32'h2);
        for (int n = 0; n < 8; n++)
        begin
            wr(`CAF_OFF_CODE0 + 12'(4 * n), {24'h0, cd[63 - 8 * n -: 8]});
            wr(`CAF_OFF_MASK0 + 12'(4 * n), {24'h0, mk[63 - 8 * n -: 8]});
        end
        wr(`CAF_OFF_IDAC, ctl);
        set_mode(32'h0);
    endtask : load
    task automatic frame(input logic ext, input logic [31:0] id,
                         input logic acc, input logic [2:0] hit);
        if (acc)
            fr_q.push_back({id, hit});
        i_bus.send(ext, id);
        repeat (2) @(posedge pclk);
    endtask : frame
    // --------------------------------
    // result watcher
    // --------------------------------
    always @(posedge pclk)
    begin
        logic [32:0] e;
        logic [34:0] f;
        if (psel && penable && pready && !pwrite && rd_q.size() > 0)
        begin
            e = rd_q.pop_front();
            if (!e[32])
                `CHK("prdata", e[31:0], prdata)
            `CHK("pslverr", 1'b0, pslverr)
        end
        if (frame_accepted === 1'b1)
        begin
            f = fr_q.size() > 0 ? fr_q.pop_front() : 35'h0;
            `CHK("frame", f, {fg_id_bytes, filter_hit_indicator})
        end
    end
    // --------------------------------
    // main sequence
    // --------------------------------
    initial
    begin
        logic [31:0] a, b, v;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("irq", 1'b0, irq)
        for (int n = 0; n < 16; n++)
        begin
            v = rnd();
            wr(`CAF_OFF_CODE0 + 12'(4 * n), v);
            rd(`CAF_OFF_CODE0 + 12'(4 * n), {24'h0, v[7:0]});
        end
        wr(`CAF_OFF_TEST, rnd());
        rd(`CAF_OFF_TEST, 32'h0);
        rd(12'h0FC, 32'h0);
        v = rnd();
        i_bus.counts(v[7:0], v[15:8]);
        wr(`CAF_OFF_RXERR, 32'hFF);
        rd(`CAF_OFF_RXERR, {24'h0, v[7:0]});
        rd(`CAF_OFF_TXERR, {24'h0, v[15:8]});
        $display("test registers done");
        a = rnd();
        b = ~a;
        load({a, b}, 64'h0007000000070001, 32'h00);
        wr(`CAF_OFF_CODE0, {24'h0, b[31:24]});
        rd(`CAF_OFF_CODE0, {24'h0, a[31:24]});
        frame(1'b1, a, 1'b1, 3'd0);
        frame(1'b1, a ^ 32'h1, 1'b0, 3'd0);
        frame(1'b1, a ^ 32'h100, 1'b0, 3'd0);
        frame(1'b0, a ^ 32'h0007FFFF, 1'b1, 3'd0);
        frame(1'b1, b ^ 32'h1, 1'b1, 3'd1);
        rd(`CAF_OFF_IDAC, 32'h01);
        rd(`CAF_OFF_IRQ_STAT, 32'h5);
        wr(`CAF_OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK("irq", 1'b1, irq)
        wr(`CAF_OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK("irq", 1'b0, irq)
        rd(`CAF_OFF_IRQ_STAT, 32'h4);
        $display("test wide filters done");
        load({{2{~a[31:16]}}, {2{a[31:16]}}}, 64'h0007000700070007,
             32'h10);
        v = rnd();
        frame(1'b0, {a[31:16], v[15:0]}, 1'b1, 3'd2);
        frame(1'b0, {a[31:16], ~a[31:16]}, 1'b1, 3'd2);
        rd(`CAF_OFF_IDAC, 32'h12);
        v = {4{a[7:0]}};
        load({{5{~a[7:0]}}, {3{a[7:0]}}}, 64'h0, 32'h20);
        frame(1'b1, v, 1'b1, 3'd5);
        load({{5{~a[7:0]}}, {3{a[7:0]}}}, 64'h0, 32'h30);
        frame(1'b1, v, 1'b0, 3'd0);
        rd(`CAF_OFF_IDAC, 32'h35);
        $display("test filter modes done");
        wr(`CAF_OFF_IRQ_STAT, 32'h7);
        set_mode(32'h1);
        rd(`CAF_OFF_RXERR, 32'h0);
        v = rnd();
        i_bus.counts(v[7:0], v[15:8]);
        set_mode(32'h5);
        rd(`CAF_OFF_RXERR, {24'h0, v[7:0]});
        rd(`CAF_OFF_TXERR, {24'h0, v[15:8]});
        set_mode(32'h1);
        i_bus.pulse(1'b1);
        repeat (2) @(posedge pclk);
        `CHK("held", 1'b1, busoff_held)
        rd(`CAF_OFF_IRQ_STAT, 32'h2);
        wr(`CAF_OFF_MISC, 32'h0);
        rd(`CAF_OFF_MISC, 32'h1);
        wr(`CAF_OFF_MISC, 32'h1);
        rd(`CAF_OFF_MISC, 32'h0);
        `CHK("recovery", 1'b1, recovery_request)
        i_bus.pulse(1'b0);
        repeat (2) @(posedge pclk);
        `CHK("recovery", 1'b0, recovery_request)
        set_mode(32'h0);
        i_bus.pulse(1'b1);
        rd(`CAF_OFF_MISC, 32'h0);
        i_bus.pulse(1'b0);
        $display("test bus-off done");
        `CHK("frames left", 32'h0, 32'(fr_q.size()))
        stop_test();
    end
endmodule : tb_can_acceptance_filter_status
